// ===== design/occ_pkg.sv
package occ_pkg;
  // register byte offsets (avalon word aligned)
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] CMPA_OFF = 4'h4;
  localparam logic [3:0] CMPB_OFF = 4'h8;
  localparam logic [3:0] STAT_OFF = 4'hC;
  localparam logic [3:0] MASK_OFF = 4'h0;
  localparam int ADDR_W = 4;
  // control register fields
  localparam int MODE_LSB = 0;
  localparam int TSEL_BIT = 3;
  localparam int FLT_BIT = 4;
  localparam int IDLE_BIT = 13;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h200F;
  // status bits
  localparam int ST_EDGE = 0;
  localparam int ST_FLT = 1;
  localparam int ST_W = 2;
  // mode encodings
  localparam logic [2:0] M_OFF = 3'h0;
  localparam logic [2:0] M_LOW1 = 3'h1;
  localparam logic [2:0] M_HIGH1 = 3'h2;
  localparam logic [2:0] M_TOG = 3'h3;
  localparam logic [2:0] M_DLY = 3'h4;
  localparam logic [2:0] M_CONT = 3'h5;
  localparam logic [2:0] M_PWM = 3'h6;
  localparam logic [2:0] M_PWMF = 3'h7;
endpackage

// ===== design/occ_core_if.sv
`timescale 1ns/1ps
`default_nettype none
// control from the register file to the compare engine and events back
interface occ_core_if;
  logic [2:0] mode;
  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic [15:0] timer;
  logic period_restart;
  logic run;
  logic fault_n;
  logic pin;
  logic rise_ev;
  logic fall_ev;
  logic fault_ev;
  modport ctrl (output mode, cmp_a, cmp_b, timer, period_restart, run,
    fault_n, input pin, rise_ev, fall_ev, fault_ev);
  modport core (input mode, cmp_a, cmp_b, timer, period_restart, run,
    fault_n, output pin, rise_ev, fall_ev, fault_ev);
endinterface
`default_nettype wire

// ===== design/occ_engine.sv
`timescale 1ns/1ps
`default_nettype none
module occ_engine (
  input wire logic clock,
  input wire logic rst_n,
  occ_core_if.core cif
);
  logic pin_ff;
  logic done_ff;
  logic armed_ff;
  logic flt_prev_ff;
  logic [2:0] mode_prev_ff;
  logic nxt_pin;
  logic nxt_done;
  logic nxt_armed;
  logic match_a;
  logic match_b;
  logic entered;
  logic fault_fall;

  assign match_a = cif.timer == cif.cmp_a;
  assign match_b = cif.timer == cif.cmp_b;
  assign entered = cif.mode != mode_prev_ff;
  assign fault_fall = flt_prev_ff & ~cif.fault_n;

  // -----------------------------------------------------------
  // output pin sequencing
  // -----------------------------------------------------------
  always_comb begin
    nxt_pin = pin_ff;
    nxt_done = done_ff;
    nxt_armed = armed_ff;
    if (entered) begin
      nxt_done = 1'b0;
      nxt_armed = 1'b0;
      case (cif.mode)
        occ_pkg::M_LOW1, occ_pkg::M_DLY, occ_pkg::M_CONT: nxt_pin = 1'b0;
        occ_pkg::M_HIGH1: nxt_pin = 1'b1;
        occ_pkg::M_PWM, occ_pkg::M_PWMF: nxt_pin = |cif.cmp_a;
        default: nxt_pin = pin_ff; // toggle keeps level
      endcase
    end else if (cif.run) begin
      case (cif.mode)
        occ_pkg::M_LOW1: if (match_a) nxt_pin = 1'b1;
        occ_pkg::M_HIGH1: if (match_a) nxt_pin = 1'b0;
        occ_pkg::M_TOG: if (match_a) nxt_pin = ~pin_ff;
        occ_pkg::M_DLY: begin
          // one pulse: rise on a, fall on b, then stay low
          if (!done_ff && match_a) nxt_pin = 1'b1;
          if (!done_ff && match_b && pin_ff) begin
            nxt_pin = 1'b0;
            nxt_done = 1'b1;
          end
        end
        occ_pkg::M_CONT: begin
          if (match_a) nxt_pin = 1'b1;
          if (match_b) nxt_pin = 1'b0;
        end
        occ_pkg::M_PWM, occ_pkg::M_PWMF: begin
          if (cif.period_restart) nxt_pin = |cif.cmp_a;
          else if (match_a) nxt_pin = 1'b0;
          // fault latches the pin low until the mode changes
          if (cif.mode == occ_pkg::M_PWMF && (fault_fall || armed_ff)) begin
            nxt_pin = 1'b0;
            nxt_armed = 1'b1;
          end
        end
        default: nxt_pin = pin_ff;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_ff <= 1'b0;
      done_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
      done_ff <= nxt_done;
      armed_ff <= nxt_armed;
    end
  end

  // mode and fault history for entry and edge detect
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_prev_ff <= occ_pkg::M_OFF;
      flt_prev_ff <= 1'b1;
    end else begin
      mode_prev_ff <= cif.mode;
      flt_prev_ff <= cif.fault_n;
    end
  end

  assign cif.pin = pin_ff;
  assign cif.rise_ev = nxt_pin & ~pin_ff;
  assign cif.fall_ev = ~nxt_pin & pin_ff;
  assign cif.fault_ev = fault_fall & (cif.mode == occ_pkg::M_PWMF);
endmodule
`default_nettype wire

// ===== design/occ_top.sv
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - mode 110 is pwm, fault ignored, start level from compare nonzero.
// - mode 111 is pwm, interrupt on falling edge of fault input.
// - fault input acts only in mode 111.
// - fault flag bit 4 set on fault, cleared by hardware, mode 111.
// - bit 3 selects time base b when set, else time base a.
// - bit 13 set halts channel while cpu idles.
// - mode 101 starts low then pulses continuously on compares.
// - mode 100 starts low and makes exactly one pulse.
// - mode 011 inverts the output on every compare event.
// - mode 010 starts high, compare forces low.
// - mode 001 starts low, compare forces high.
// - mode 000 disables the channel.
// - disabled channel hands the pin to general purpose i/o.
// - output changes when selected timer equals compare value.
// - toggle mode interrupts on both output edges.
module occ_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [occ_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] time_base_a,
  input wire logic [15:0] time_base_b,
  input wire logic period_restart_a,
  input wire logic period_restart_b,
  input wire logic cpu_idle,
  input wire logic fault_input_a,
  input wire logic gpio_level,
  output logic compare_output_pin,
  output logic irq
);
  // -----------------------------------------------------------
  // reset release
  // -----------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // -----------------------------------------------------------
  // registers
  // -----------------------------------------------------------
  logic [15:0] ctrl_ff;
  logic [15:0] cmpa_ff;
  logic [15:0] cmpb_ff;
  logic [occ_pkg::ST_W-1:0] stat_ff;
  logic [occ_pkg::ST_W-1:0] mask_ff;
  logic fault_flag_ff;
  logic ack_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic pin_out_ff;
  logic irq_ff;
  logic wr_go;
  logic rd_go;
  logic [2:0] mode;
  logic [occ_pkg::ST_W-1:0] ev_set;
  logic edge_irq;

  occ_core_if cif ();

  assign mode = ctrl_ff[occ_pkg::MODE_LSB +: 3];
  // one wait state: read data loads on the first edge so it stands at
  // the accept edge; a write lands only at the accept edge itself
  assign wr_go = avs_write & ack_ff;
  assign rd_go = avs_read & ~ack_ff;

  // decode of a register offset, used by write and read paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = a == off;
  endfunction

  // handshake: waitrequest low for one cycle after a cycle of wait
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
      // waitrequest kept as its own flop so the pin comes from a register
      wait_ff <= ~((avs_read | avs_write) & ~ack_ff);
    end
  end

  // control and compare values, write only while the master writes
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_ff <= occ_pkg::CTRL_RST;
      cmpa_ff <= 16'h0000;
      cmpb_ff <= 16'h0000;
    end else if (wr_go) begin
      // software must stop the timer first, nothing here checks it
      if (hit(avs_address, occ_pkg::CTRL_OFF)) begin
        ctrl_ff <= avs_writedata[15:0] & occ_pkg::CTRL_WMASK;
      end
      if (hit(avs_address, occ_pkg::CMPA_OFF)) begin
        cmpa_ff <= avs_writedata[15:0];
      end
      if (hit(avs_address, occ_pkg::CMPB_OFF)) begin
        cmpb_ff <= avs_writedata[15:0];
      end
    end
  end

  // mask lives in the upper half of the status word
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mask_ff <= '0;
    end else if (wr_go && hit(avs_address, occ_pkg::STAT_OFF)) begin
      mask_ff <= avs_writedata[16 +: occ_pkg::ST_W];
    end
  end

  // -----------------------------------------------------------
  // compare engine
  // -----------------------------------------------------------
  assign cif.mode = mode;
  assign cif.cmp_a = cmpa_ff;
  assign cif.cmp_b = cmpb_ff;
  assign cif.timer = ctrl_ff[occ_pkg::TSEL_BIT] ? time_base_b
                                               : time_base_a;
  assign cif.period_restart = ctrl_ff[occ_pkg::TSEL_BIT] ? period_restart_b
                                                        : period_restart_a;
  // halting in idle freezes compare activity, not the pin level
  assign cif.run = (mode != occ_pkg::M_OFF) &
                   ~(ctrl_ff[occ_pkg::IDLE_BIT] & cpu_idle);
  assign cif.fault_n = (mode == occ_pkg::M_PWMF) ? fault_input_a
                                                : 1'b1;

  occ_engine u_engine (
    .clock(clock),
    .rst_n(rst_n_ff),
    .cif(cif)
  );

  // -----------------------------------------------------------
  // fault flag and interrupt events
  // -----------------------------------------------------------
  // hardware clears the flag once the channel leaves mode 111
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      fault_flag_ff <= 1'b0;
    end else if (cif.fault_ev) begin
      fault_flag_ff <= 1'b1;
    end else if (mode != occ_pkg::M_PWMF) begin
      fault_flag_ff <= 1'b0;
    end
  end

  // edge that raises the interrupt depends on the mode
  always_comb begin
    case (mode)
      occ_pkg::M_LOW1: edge_irq = cif.rise_ev;
      occ_pkg::M_HIGH1, occ_pkg::M_DLY, occ_pkg::M_CONT:
        edge_irq = cif.fall_ev;
      occ_pkg::M_TOG: edge_irq = cif.rise_ev | cif.fall_ev;
      default: edge_irq = 1'b0;
    endcase
  end

  assign ev_set[occ_pkg::ST_EDGE] = edge_irq & cif.run;
  assign ev_set[occ_pkg::ST_FLT] = cif.fault_ev;

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      stat_ff <= '0;
    end else begin
      if (wr_go && hit(avs_address, occ_pkg::STAT_OFF)) begin
        stat_ff <= (stat_ff & ~avs_writedata[occ_pkg::ST_W-1:0]) | ev_set;
      end else begin
        stat_ff <= stat_ff | ev_set;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // -----------------------------------------------------------
  // pin and read data
  // -----------------------------------------------------------
  // disabled channel passes the port level through one register stage
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_out_ff <= 1'b0;
    end else if (mode == occ_pkg::M_OFF) begin
      pin_out_ff <= gpio_level;
    end else begin
      pin_out_ff <= cif.pin;
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_go) begin
      rdata_ff <= 32'h00000000; // unmapped reads as zero
      if (hit(avs_address, occ_pkg::CTRL_OFF)) begin
        rdata_ff[15:0] <= ctrl_ff | ({15'h0000, fault_flag_ff}
                                     << occ_pkg::FLT_BIT);
      end
      if (hit(avs_address, occ_pkg::CMPA_OFF)) begin
        rdata_ff[15:0] <= cmpa_ff;
      end
      if (hit(avs_address, occ_pkg::CMPB_OFF)) begin
        rdata_ff[15:0] <= cmpb_ff;
      end
      if (hit(avs_address, occ_pkg::STAT_OFF)) begin
        rdata_ff <= {14'h0000, mask_ff, 14'h0000, stat_ff};
      end
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign compare_output_pin = pin_out_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

// ===== testbench/occ_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module occ_monitor (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [occ_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic period_restart_a,
  input wire logic cpu_idle,
  input wire logic fault_input_a,
  input wire logic gpio_level,
  input wire logic compare_output_pin,
  input wire logic irq
);
  // ----
  // shadow of written fields
  // ----
  logic [2:0] mode_ff;
  logic [1:0] mask_ff;
  logic nz_ff;
  logic sel_ff;
  logic idle_ff;
  logic ack;
  assign ack = avs_write && !avs_waitrequest;
  // a write counts only at its accept edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= 3'h0;
      mask_ff <= 2'h0;
      nz_ff <= 1'b0;
      sel_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else if (ack) begin
      if (avs_address == occ_pkg::CTRL_OFF) begin
        mode_ff <= avs_writedata[2:0];
        sel_ff <= avs_writedata[3];
        idle_ff <= avs_writedata[13];
      end
      if (avs_address == occ_pkg::CMPA_OFF) begin
        nz_ff <= avs_writedata[15:0] != 16'h0000;
      end
      if (avs_address == occ_pkg::STAT_OFF) begin
        mask_ff <= avs_writedata[17:16];
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_wait_one: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("long accept");
  a_entry_low: assert property (
    ack && avs_address == occ_pkg::CTRL_OFF
    && avs_writedata[2:0] inside {3'h1, 3'h4, 3'h5}
    |-> ##3 !compare_output_pin) else $error("entry not low");
  a_entry_high: assert property (
    ack && avs_address == occ_pkg::CTRL_OFF && avs_writedata[2:0] == 3'h2
    |-> ##3 compare_output_pin) else $error("entry not high");
  a_gpio_follow: assert property (
    mode_ff == 3'h0 && $past(mode_ff) == 3'h0
    |-> compare_output_pin == $past(gpio_level)) else $error("gpio lost");
  a_pwm_restart: assert property (
    mode_ff == 3'h6 && !sel_ff && nz_ff && period_restart_a
    |-> ##[1:3] compare_output_pin) else $error("no period rise");
  a_fault_low: assert property (
    mode_ff == 3'h7 && $fell(fault_input_a)
    |-> ##[1:4] !compare_output_pin) else $error("fault not low");
  a_irq_masked: assert property (
    mask_ff == 2'h0 && $past(mask_ff) == 2'h0 |-> !irq)
    else $error("masked irq");
  a_idle_hold: assert property (
    idle_ff && mode_ff == 3'h3 && cpu_idle && $past(cpu_idle, 3)
    |-> $stable(compare_output_pin)) else $error("idle moved");
endmodule
`default_nettype wire

// ===== testbench/occ_load.sv
`timescale 1ns/1ps
`default_nettype none
// load on the pin: counts switching edges, sampled once a cycle
module occ_load (
  input wire logic clock,
  input wire logic drive,
  output var int rises,
  output var int falls
);
  logic last_ff;
  // an unknown level counts as no edge
  always_ff @(posedge clock) begin
    last_ff <= drive;
    if (drive && !last_ff)
      rises <= rises + 1;
    if (!drive && last_ff)
      falls <= falls + 1;
  end
endmodule
`default_nettype wire

// ===== testbench/occ_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module occ_top_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wait_s;
  logic [15:0] tma = 16'h000F;
  logic [15:0] tmb = 16'h000F;
  logic pra = 1'b0;
  logic prb = 1'b0;
  logic cpu_idle = 1'b0;
  logic flt = 1'b1;
  logic gpio = 1'b0;
  logic pin;
  logic irq;
  logic [31:0] rd;
  int rises, falls, r0, n_errors = 0, n_tests = 0;
  always #2 clock = ~clock;
  occ_top occ_top_i (.clock(clock), .nrst(nrst), .avs_address(adr),
    .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd),
    .avs_readdata(rdata), .avs_waitrequest(wait_s), .time_base_a(tma),
    .time_base_b(tmb), .period_restart_a(pra), .period_restart_b(prb),
    .cpu_idle(cpu_idle), .fault_input_a(flt), .gpio_level(gpio),
    .compare_output_pin(pin), .irq(irq));
  occ_load occ_load_i (.clock(clock), .drive(pin), .rises(rises),
    .falls(falls));
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // held until waitrequest is sampled low, dropped after that edge
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
    @(posedge clock);
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    @(posedge clock);
    while (wait_s !== 1'b0)
      @(posedge clock);
    rd = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one period on the chosen timer, the other parked off any match
  task automatic sweep(input logic b);
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      tma <= b ? 16'h000F : i[15:0];
      tmb <= b ? i[15:0] : 16'h000F;
      pra <= !b && i == 0;
      prb <= b && i == 0;
    end
    @(posedge clock);
    tma <= 16'h000F;
    tmb <= 16'h000F;
    cyc(4);
  endtask
  // ----
  // scenarios; timers stay parked at every control write
  // ----
  task automatic t_regs();
    bus(0, occ_pkg::CTRL_OFF, 32'h0);
    chk(rd, {16'h0, occ_pkg::CTRL_RST});
    bus(1, occ_pkg::CTRL_OFF, 32'hFFFF);
    bus(0, occ_pkg::CTRL_OFF, 32'h0);
    chk(rd, {16'h0, occ_pkg::CTRL_WMASK});
    bus(1, occ_pkg::CTRL_OFF, 32'h0);
    bus(0, occ_pkg::STAT_OFF, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_shots();
    bus(1, occ_pkg::CMPA_OFF, 32'h5);
    bus(1, occ_pkg::STAT_OFF, 32'h00010003);
    bus(1, occ_pkg::CTRL_OFF, 32'h1);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    sweep(0);
    chk({31'h0, pin}, 32'h1);
    bus(0, occ_pkg::STAT_OFF, 32'h0);
    chk(rd & 32'h3, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1, occ_pkg::STAT_OFF, 32'h00010001);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    bus(1, occ_pkg::CTRL_OFF, 32'hA);
    sweep(0);
    chk({31'h0, pin}, 32'h1);
    sweep(1);
    chk({31'h0, pin}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    bus(1, occ_pkg::STAT_OFF, 32'h3);
  endtask
  task automatic t_pulses();
    bus(1, occ_pkg::CMPA_OFF, 32'h3);
    bus(1, occ_pkg::CMPB_OFF, 32'h8);
    for (int m = 4; m < 6; m++) begin
      bus(1, occ_pkg::CTRL_OFF, 32'(m));
      cyc(3);
      r0 = rises;
      sweep(0);
      sweep(0);
      chk(32'(rises - r0), 32'(m - 3));
    end
  endtask
  task automatic t_toggle();
    bus(1, occ_pkg::CTRL_OFF, 32'h3);
    bus(1, occ_pkg::STAT_OFF, 32'h3);
    r0 = rises + falls;
    sweep(0);
    bus(0, occ_pkg::STAT_OFF, 32'h0);
    chk(rd & 32'h1, 32'h1);
    bus(1, occ_pkg::STAT_OFF, 32'h3);
    sweep(0);
    chk(32'(rises + falls - r0), 32'h2);
    bus(0, occ_pkg::STAT_OFF, 32'h0);
    chk(rd & 32'h1, 32'h1);
    bus(1, occ_pkg::CTRL_OFF, 32'h2003);
    cpu_idle <= 1'b1;
    cyc(3);
    r0 = rises + falls;
    sweep(0);
    chk(32'(rises + falls - r0), 32'h0);
    cpu_idle <= 1'b0;
    sweep(0);
    chk(32'(rises + falls - r0), 32'h1);
  endtask
  task automatic t_pwm();
    bus(1, occ_pkg::CMPA_OFF, 32'h4);
    bus(1, occ_pkg::CTRL_OFF, 32'h7);
    cyc(3);
    chk({31'h0, pin}, 32'h1);
    r0 = rises;
    sweep(0);
    sweep(0);
    chk(32'(rises - r0), 32'h1);
    bus(1, occ_pkg::STAT_OFF, 32'h3);
    flt <= 1'b0;
    r0 = rises;
    sweep(0);
    chk(32'(rises - r0), 32'h0);
    bus(0, occ_pkg::STAT_OFF, 32'h0);
    chk(rd & 32'h2, 32'h2);
    bus(0, occ_pkg::CTRL_OFF, 32'h0);
    chk(rd & 32'h10, 32'h10);
    flt <= 1'b1;
    bus(1, occ_pkg::CTRL_OFF, 32'h6);
    bus(0, occ_pkg::CTRL_OFF, 32'h0);
    chk(rd & 32'h10, 32'h0);
    bus(1, occ_pkg::STAT_OFF, 32'h3);
    chk({31'h0, pin}, 32'h1);
    flt <= 1'b0;
    r0 = falls;
    sweep(0);
    chk(32'(falls - r0), 32'h1);
    bus(0, occ_pkg::STAT_OFF, 32'h0);
    chk(rd & 32'h3, 32'h0);
    flt <= 1'b1;
  endtask
  task automatic t_gpio();
    bus(1, occ_pkg::CTRL_OFF, 32'h0);
    for (int v = 1; v >= 0; v--) begin
      gpio <= v[0];
      cyc(3);
      chk({31'h0, pin}, 32'(v));
    end
  endtask
  initial begin
    cyc(8);
    nrst <= 1'b1;
    cyc(4);
    t_regs();
    t_shots();
    t_pulses();
    t_toggle();
    t_pwm();
    t_gpio();
    print_verdict();
  end
  // a hang counts as a mismatch
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule
bind occ_top occ_monitor occ_monitor_i (.clock(clock), .nrst(nrst),
  .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .period_restart_a(period_restart_a), .cpu_idle(cpu_idle),
  .fault_input_a(fault_input_a), .gpio_level(gpio_level),
  .compare_output_pin(compare_output_pin), .irq(irq));
`default_nettype wire
